// ---- core/adrlm_top.sv ----
// Summary of operation
// - power-on sets the power-on flag; only a written one clears it
// - external reset pin pulled low sets the pin reset flag; write one clears
// - watchdog timeout or badly timed service sets watchdog flag; write one clears
// - overtemperature sets the overtemperature reset flag; write one clears
// - regulator undervoltage sets the undervoltage reset flag; write one clears
// - bus activity causing wake from sleep sets bus wake flag; write one clears
// - wake input event causing wake from sleep sets its flag (stop wake sets none); write one clears
// - two-bit slew select field, reset value selects the 20 kbit/s setting
// - bus transmitter enabled only while power stage enable is set
// - current limitation sets status bit and disables transceiver after fixed delay
// - transmit low drives bus dominant; transmit high turns the driver off
// - undriven transmit input reads high, leaving bus recessive
// - receive pin high for recessive bus, low for dominant bus
// - stop: transmitter off, long dominant then rise sets flag and wakes if enabled
// - sleep: long dominant then rise wakes through reset, sets bus wake flag
// - current source on needs power stage, input or calibration source selected and source enable
// - two-bit level field picks 40/120/320/800 uA; reset gives lowest
// - current source forced off in stop or sleep mode
// - four-bit select routes one of eleven sources to converter output
// - gain bit one gives low, zero high amplification; reset clears it
// - read/write current source enable, cleared by reset
// - power-on reset sets power-on flag and clears all other status flags
// - watchdog, overtemperature, undervoltage resets clear control, interrupt and current limit flags, keep reset status flags
// - reset status flags stay set until software or power-on reset clears them
`timescale 1ns/1ps
`default_nettype none
module adrlm_top #(
  parameter int unsigned WAKE_FILTER_CYC = adrlm_pkg::WAKE_FILTER_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [1:0] mode_i,
  input wire logic pin_reset_i,
  input wire logic wdog_timeout_i,
  input wire logic wdog_bad_service_i,
  input wire logic overtemp_i,
  input wire logic undervolt_i,
  input wire logic lin_bus_i,
  input wire logic txd_i,
  input wire logic txd_drive_i,
  input wire logic lin_cur_limit_i,
  input wire logic wake_input_i,
  input wire logic spi_sck_i,
  input wire logic spi_mosi_i,
  input wire logic spi_ss_n_i,
  output logic spi_miso_o,
  output logic rxd_o,
  output logic lin_o,
  output logic lin_oe_o,
  output logic [1:0] slew_select_o,
  output logic tx_enable_o,
  output logic cs_on_o,
  output logic [1:0] current_level_select_o,
  output logic [3:0] converter_source_o,
  output logic converter_source_valid_o,
  output logic sense_gain_select_o,
  output logic sys_wake_o,
  output logic wake_reset_o
);
  // ==========================================================
  // input synchronisers
  logic [12:0] sync1_ff;
  logic [12:0] sync2_ff;

  for (genvar i = 0; i < 13; i++) begin : g_sync
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        sync1_ff[i] <= adrlm_pkg::SYNC_IDLE[i];
        sync2_ff[i] <= adrlm_pkg::SYNC_IDLE[i];
      end else if (ce_i) begin
        sync1_ff[i] <= (i == 0) ? pin_reset_i :
                       (i == 1) ? wdog_timeout_i :
                       (i == 2) ? wdog_bad_service_i :
                       (i == 3) ? overtemp_i :
                       (i == 4) ? undervolt_i :
                       (i == 5) ? lin_bus_i :
                       (i == 6) ? txd_i :
                       (i == 7) ? txd_drive_i :
                       (i == 8) ? lin_cur_limit_i :
                       (i == 9) ? wake_input_i :
                       (i == 10) ? spi_sck_i :
                       (i == 11) ? spi_mosi_i : spi_ss_n_i;
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  // ==========================================================
  // mode decode and reset sources
  wire mode_run = (mode_i == adrlm_pkg::ADRLM_RUN);
  wire mode_stop = (mode_i == adrlm_pkg::ADRLM_STOP);
  wire mode_sleep = (mode_i == adrlm_pkg::ADRLM_SLEEP);
  wire lowpow = mode_stop | mode_sleep;

  wire ev_pin = ~sync2_ff[adrlm_pkg::S_PINRST];
  wire ev_wdog = sync2_ff[adrlm_pkg::S_WDTO] | sync2_ff[adrlm_pkg::S_WDBAD];
  wire ev_otemp = sync2_ff[adrlm_pkg::S_OTEMP];
  wire ev_uvolt = sync2_ff[adrlm_pkg::S_UVOLT];
  // warm resets hold the control registers at reset value while present
  wire warm_rst = ev_pin | ev_wdog | ev_otemp | ev_uvolt;

  // ==========================================================
  // register port
  logic spi_wr;
  logic [6:0] spi_addr;
  logic [7:0] spi_wdata;
  logic [7:0] rdata;

  adrlm_spi_port u_spi (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sck_s_i(sync2_ff[adrlm_pkg::S_SCK]),
    .mosi_s_i(sync2_ff[adrlm_pkg::S_MOSI]),
    .ss_n_s_i(sync2_ff[adrlm_pkg::S_SSN]),
    .rdata_i(rdata),
    .wr_o(spi_wr),
    .addr_o(spi_addr),
    .wdata_o(spi_wdata),
    .miso_o(spi_miso_o)
  );

  wire wr_system_control_reg = spi_wr && spi_addr == adrlm_pkg::SYSTEM_CONTROL_REG_OFS;
  wire wr_system_status_reg = spi_wr && spi_addr == adrlm_pkg::SYSTEM_STATUS_REG_OFS;
  wire wr_amux = spi_wr && spi_addr == adrlm_pkg::AMUX_OFS;
  wire wr_imask = spi_wr && spi_addr == adrlm_pkg::IMASK_OFS;
  wire wr_iflag = spi_wr && spi_addr == adrlm_pkg::IFLAG_OFS;
  wire wr_rsr = spi_wr && spi_addr == adrlm_pkg::RSR_OFS;

  // ==========================================================
  // control registers
  logic [7:0] system_control_reg_ff;
  logic [7:0] amux_ff;
  logic [7:0] imask_ff;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      system_control_reg_ff <= adrlm_pkg::SYSTEM_CONTROL_REG_RST;
      amux_ff <= adrlm_pkg::AMUX_RST;
      imask_ff <= adrlm_pkg::IMASK_RST;
    end else if (ce_i) begin
      if (warm_rst) begin
        system_control_reg_ff <= adrlm_pkg::SYSTEM_CONTROL_REG_RST;
        amux_ff <= adrlm_pkg::AMUX_RST;
        imask_ff <= adrlm_pkg::IMASK_RST;
      end else begin
        if (wr_system_control_reg) begin
          system_control_reg_ff <= spi_wdata & 8'h07;
        end
        if (wr_amux) begin
          amux_ff <= spi_wdata;
        end
        if (wr_imask) begin
          imask_ff <= spi_wdata & 8'h04;
        end
      end
    end
  end

  wire pse = system_control_reg_ff[adrlm_pkg::SYSTEM_CONTROL_REG_PSE];
  wire [3:0] ss = amux_ff[adrlm_pkg::AMUX_SS_LO +: 4];
  wire bus_ie = imask_ff[adrlm_pkg::IMASK_BUSIE];

  assign slew_select_o = system_control_reg_ff[adrlm_pkg::SYSTEM_CONTROL_REG_SLEW_LO +: 2];

  // ==========================================================
  // bus wake detection in stop and sleep
  logic bus_wake;
  wire bus_s = sync2_ff[adrlm_pkg::S_BUS];

  adrlm_wake_det #(
    .FILT_CYC(WAKE_FILTER_CYC)
  ) u_wake (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(lowpow),
    .bus_i(bus_s),
    .wake_o(bus_wake)
  );

  wire stop_bus_wake = bus_wake & mode_stop & bus_ie;
  wire sleep_bus_wake = bus_wake & mode_sleep;

  // ==========================================================
  // wake input: level stored on entry and re-armed on each wake, so requests pulse
  logic lowpow_q_ff;
  logic wkin_ref_ff;
  wire wkin_s = sync2_ff[adrlm_pkg::S_WKIN];
  wire wkin_event = lowpow & lowpow_q_ff & (wkin_s != wkin_ref_ff);
  wire stop_in_wake = wkin_event & mode_stop;
  wire sleep_in_wake = wkin_event & mode_sleep;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lowpow_q_ff <= 1'b0;
      wkin_ref_ff <= 1'b0;
      sys_wake_o <= 1'b0;
      wake_reset_o <= 1'b0;
    end else if (ce_i) begin
      lowpow_q_ff <= lowpow;
      if ((lowpow & ~lowpow_q_ff) | wkin_event) begin
        wkin_ref_ff <= wkin_s;
      end
      sys_wake_o <= stop_bus_wake | stop_in_wake;
      wake_reset_o <= sleep_bus_wake | sleep_in_wake;
    end
  end

  // ==========================================================
  // bus interrupt flag, set wins over the written clear
  logic [7:0] iflag_ff;
  wire [7:0] iflag_set = {5'h00, stop_bus_wake, 2'h0};
  wire [7:0] iflag_clr = wr_iflag ? spi_wdata : 8'h00;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      iflag_ff <= adrlm_pkg::IFLAG_RST;
    end else if (ce_i) begin
      if (warm_rst) begin
        iflag_ff <= adrlm_pkg::IFLAG_RST;
      end else begin
        iflag_ff <= (iflag_ff & ~iflag_clr) | iflag_set;
      end
    end
  end

  // ==========================================================
  // reset source status: cleared only by power-on or written ones
  logic [7:0] rsr_ff;
  logic [7:0] rsr_set;
  wire [7:0] rsr_clr = wr_rsr ? spi_wdata : 8'h00;

  always_comb begin
    rsr_set = 8'h00;
    rsr_set[adrlm_pkg::RSR_PIN] = ev_pin;
    rsr_set[adrlm_pkg::RSR_WDOG] = ev_wdog;
    rsr_set[adrlm_pkg::RSR_OTEMP] = ev_otemp;
    rsr_set[adrlm_pkg::RSR_UVOLT] = ev_uvolt;
    rsr_set[adrlm_pkg::RSR_BUSWK] = sleep_bus_wake;
    rsr_set[adrlm_pkg::RSR_INWK] = sleep_in_wake;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rsr_ff <= adrlm_pkg::RSR_POR_VAL;
    end else if (ce_i) begin
      rsr_ff <= ((rsr_ff & ~rsr_clr) | rsr_set) & 8'h7F;
    end
  end

  // ==========================================================
  // transmitter, current limit shutdown, receiver
  logic cl_flag_ff;
  logic cl_off_ff;
  logic [11:0] cl_cnt_ff;
  logic rxd_ff;
  logic lin_oe_ff;
  localparam logic [11:0] CL_LIMIT = 12'(adrlm_pkg::CL_DELAY_CYC);
  wire clim_s = sync2_ff[adrlm_pkg::S_CLIM];
  wire cl_clear = wr_system_status_reg & spi_wdata[adrlm_pkg::SYSTEM_STATUS_REG_CL];
  // the transmit input floats high when the controller does not drive it
  wire txd_eff = sync2_ff[adrlm_pkg::S_TXD] | ~sync2_ff[adrlm_pkg::S_TXDEN];
  wire tx_en = pse & mode_run & ~cl_off_ff;

  assign tx_enable_o = tx_en;
  assign lin_o = 1'b0;
  assign lin_oe_o = lin_oe_ff;
  assign rxd_o = rxd_ff;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cl_flag_ff <= 1'b0;
      cl_off_ff <= 1'b0;
      cl_cnt_ff <= 12'h000;
      rxd_ff <= 1'b1;
      lin_oe_ff <= 1'b0;
    end else if (ce_i) begin
      rxd_ff <= bus_s;
      lin_oe_ff <= tx_en & ~txd_eff;
      if (warm_rst) begin
        cl_flag_ff <= 1'b0;
        cl_off_ff <= 1'b0;
        cl_cnt_ff <= 12'h000;
      end else begin
        // the shutdown holds until software acknowledges the status bit
        cl_flag_ff <= (cl_flag_ff & ~cl_clear) | (clim_s & tx_en);
        if (cl_clear & ~(clim_s & tx_en)) begin
          cl_off_ff <= 1'b0;
        end else if (cl_cnt_ff >= CL_LIMIT - 12'h001) begin
          cl_off_ff <= 1'b1;
        end
        if (clim_s & tx_en & cl_cnt_ff < CL_LIMIT) begin
          cl_cnt_ff <= cl_cnt_ff + 12'h001;
        end else if (~clim_s) begin
          cl_cnt_ff <= 12'h000;
        end
      end
    end
  end

  // ==========================================================
  // analog input current source and multiplexer
  logic cs_on_ff;
  logic [3:0] src_ff;
  logic src_valid_ff;
  wire cs_sel = (ss == adrlm_pkg::SRC_INPUT) | (ss == adrlm_pkg::SRC_CALIB);
  wire cs_req = pse & cs_sel & amux_ff[adrlm_pkg::AMUX_CURRENT_SOURCE_ENABLE] & ~lowpow;
  wire src_ok = (ss <= adrlm_pkg::SRC_LAST) & (ss != adrlm_pkg::SRC_UNUSED_7);

  assign cs_on_o = cs_on_ff;
  assign converter_source_o = src_ff;
  assign converter_source_valid_o = src_valid_ff;
  assign current_level_select_o = amux_ff[adrlm_pkg::AMUX_LVL_LO +: 2];
  assign sense_gain_select_o = amux_ff[adrlm_pkg::AMUX_GAIN];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cs_on_ff <= 1'b0;
      src_ff <= 4'h0;
      src_valid_ff <= 1'b1;
    end else if (ce_i) begin
      cs_on_ff <= cs_req;
      src_ff <= ss;
      src_valid_ff <= src_ok;
    end
  end

  // ==========================================================
  // read data
  wire [7:0] system_status_reg_rd = {6'h00, wkin_s, cl_flag_ff};

  assign rdata = (spi_addr == adrlm_pkg::SYSTEM_CONTROL_REG_OFS) ? system_control_reg_ff :
                 (spi_addr == adrlm_pkg::SYSTEM_STATUS_REG_OFS) ? system_status_reg_rd :
                 (spi_addr == adrlm_pkg::AMUX_OFS) ? amux_ff :
                 (spi_addr == adrlm_pkg::IMASK_OFS) ? imask_ff :
                 (spi_addr == adrlm_pkg::IFLAG_OFS) ? iflag_ff :
                 (spi_addr == adrlm_pkg::RSR_OFS) ? rsr_ff :
                 adrlm_pkg::RD_UNMAPPED;
endmodule : adrlm_top
`default_nettype wire

// ---- core/adrlm_pkg.sv ----
package adrlm_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_MHZ = 200;
  // bus dominant time that qualifies a wake, in ns
  localparam int unsigned WAKE_FILTER_NS = 50000;
  localparam int unsigned WAKE_FILTER_CYC = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
  // time in current limitation before the transceiver is shut off, in ns
  localparam int unsigned CL_DELAY_NS = 10000;
  localparam int unsigned CL_DELAY_CYC = (CL_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CL_CNT_W = 12;
  localparam int unsigned WAKE_CNT_W = 16;

  // ==========================================================
  // serial register port framing
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CNT_W = 5;

  // ==========================================================
  // register offsets
  localparam logic [6:0] SYSTEM_CONTROL_REG_OFS = 7'h0C;
  localparam logic [6:0] SYSTEM_STATUS_REG_OFS = 7'h0E;
  localparam logic [6:0] AMUX_OFS = 7'h08;
  localparam logic [6:0] IMASK_OFS = 7'h09;
  localparam logic [6:0] IFLAG_OFS = 7'h0A;
  localparam logic [6:0] RSR_OFS = 7'h0D;

  // ==========================================================
  // field positions
  localparam int unsigned RSR_POR = 0;
  localparam int unsigned RSR_PIN = 1;
  localparam int unsigned RSR_WDOG = 2;
  localparam int unsigned RSR_OTEMP = 3;
  localparam int unsigned RSR_UVOLT = 4;
  localparam int unsigned RSR_BUSWK = 5;
  localparam int unsigned RSR_INWK = 6;
  localparam int unsigned SYSTEM_CONTROL_REG_PSE = 0;
  localparam int unsigned SYSTEM_CONTROL_REG_SLEW_LO = 1;
  localparam int unsigned SYSTEM_STATUS_REG_CL = 0;
  localparam int unsigned SYSTEM_STATUS_REG_WKIN = 1;
  localparam int unsigned AMUX_SS_LO = 0;
  localparam int unsigned AMUX_GAIN = 4;
  localparam int unsigned AMUX_LVL_LO = 5;
  localparam int unsigned AMUX_CURRENT_SOURCE_ENABLE = 7;
  localparam int unsigned IMASK_BUSIE = 2;
  localparam int unsigned IFLAG_BUSIF = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] RSR_POR_VAL = 8'h01;
  localparam logic [7:0] SYSTEM_CONTROL_REG_RST = 8'h00;
  localparam logic [1:0] SLEW_20K = 2'h0;
  localparam logic [7:0] AMUX_RST = 8'h00;
  localparam logic [7:0] IMASK_RST = 8'h00;
  localparam logic [7:0] IFLAG_RST = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ==========================================================
  // analog multiplexer sources
  localparam logic [3:0] SRC_INPUT = 4'hA;
  localparam logic [3:0] SRC_CALIB = 4'hB;
  localparam logic [3:0] SRC_UNUSED_7 = 4'h7;
  localparam logic [3:0] SRC_LAST = 4'hB;

  // ==========================================================
  // synchroniser bit positions and idle levels
  localparam int unsigned NSYNC = 13;
  localparam int unsigned S_PINRST = 0;
  localparam int unsigned S_WDTO = 1;
  localparam int unsigned S_WDBAD = 2;
  localparam int unsigned S_OTEMP = 3;
  localparam int unsigned S_UVOLT = 4;
  localparam int unsigned S_BUS = 5;
  localparam int unsigned S_TXD = 6;
  localparam int unsigned S_TXDEN = 7;
  localparam int unsigned S_CLIM = 8;
  localparam int unsigned S_WKIN = 9;
  localparam int unsigned S_SCK = 10;
  localparam int unsigned S_MOSI = 11;
  localparam int unsigned S_SSN = 12;
  localparam logic [12:0] SYNC_IDLE = 13'h1061;

  // ==========================================================
  // operating modes, gray along run -> stop -> sleep
  typedef enum logic [1:0] {
    ADRLM_RUN = 2'h0,
    ADRLM_STOP = 2'h1,
    ADRLM_SLEEP = 2'h3
  } adrlm_mode_t;
endpackage : adrlm_pkg

// ---- core/adrlm_spi_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module adrlm_spi_port (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sck_s_i,
  input wire logic mosi_s_i,
  input wire logic ss_n_s_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  output logic miso_o
);
  // ==========================================================
  // frame: write flag, 7-bit address, 8 data bits, msb first, mode 0
  logic sck_q_ff;
  logic [7:0] sh_ff;
  logic [4:0] cnt_ff;
  logic [7:0] tx_ff;
  logic rw_ff;
  wire rise = sck_s_i & ~sck_q_ff;
  wire fall = ~sck_s_i & sck_q_ff;
  wire [7:0] shin = {sh_ff[6:0], mosi_s_i};
  wire last_bit = (cnt_ff == 5'(adrlm_pkg::FRAME_BITS - 1));

  assign miso_o = tx_ff[7];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sck_q_ff <= 1'b0;
      sh_ff <= 8'h00;
      cnt_ff <= 5'h00;
      tx_ff <= 8'h00;
      rw_ff <= 1'b0;
      addr_o <= 7'h00;
      wdata_o <= 8'h00;
      wr_o <= 1'b0;
    end else if (ce_i) begin
      sck_q_ff <= sck_s_i;
      wr_o <= 1'b0;
      if (ss_n_s_i) begin
        cnt_ff <= 5'h00;
      end else if (rise && cnt_ff < 5'(adrlm_pkg::FRAME_BITS)) begin
        sh_ff <= shin;
        cnt_ff <= cnt_ff + 5'h01;
        if (cnt_ff == 5'h07) begin
          rw_ff <= shin[7];
          addr_o <= shin[6:0];
        end
        if (last_bit && rw_ff) begin
          wdata_o <= shin;
          wr_o <= 1'b1;
        end
      end else if (fall && cnt_ff == 5'h08) begin
        tx_ff <= rdata_i;
      end else if (fall && cnt_ff > 5'h08) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end
endmodule : adrlm_spi_port
`default_nettype wire

// ---- core/adrlm_wake_det.sv ----
`timescale 1ns/1ps
`default_nettype none
module adrlm_wake_det #(
  parameter int unsigned FILT_CYC = adrlm_pkg::WAKE_FILTER_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic bus_i,
  output logic wake_o
);
  // ==========================================================
  // dominant phase counter, saturating so long faults cannot wrap
  localparam logic [15:0] FILT = 16'(FILT_CYC);
  logic [15:0] cnt_ff;
  logic bus_q_ff;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_ff <= 16'h0000;
      bus_q_ff <= 1'b1;
      wake_o <= 1'b0;
    end else if (ce_i) begin
      bus_q_ff <= bus_i;
      wake_o <= 1'b0;
      if (!en_i) begin
        cnt_ff <= 16'h0000;
      end else if (!bus_i) begin
        if (cnt_ff < FILT) begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end else begin
        wake_o <= ~bus_q_ff & (cnt_ff >= FILT);
        cnt_ff <= 16'h0000;
      end
    end
  end
endmodule : adrlm_wake_det
`default_nettype wire

// ---- test/adrlm_mcu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adrlm_mcu_model (
  input wire logic sys_clk_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic ss_n_o,
  output logic rd_vld_o,
  output logic [7:0] rd_o
);
  // ==========================================================
  // serial master, mode 0
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b1;
    ss_n_o = 1'b1;
    rd_vld_o = 1'b0;
    rd_o = 8'h00;
  end
  // 6 clk per sck phase keeps above the 4 clk the synchroniser needs
  task xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {w, a, d};
    @(negedge sys_clk_i);
    ss_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = f[i];
      repeat (6) @(negedge sys_clk_i);
      if (i < 8) rd_o[i] = miso_i;
      sck_o = 1'b1;
      repeat (6) @(negedge sys_clk_i);
      sck_o = 1'b0;
    end
    repeat (6) @(negedge sys_clk_i);
    ss_n_o = 1'b1;
    // released data line must not keep showing the last bit
    mosi_o = ~mosi_o;
    rd_vld_o = !w;
    @(negedge sys_clk_i);
    rd_vld_o = 1'b0;
    repeat (4) @(negedge sys_clk_i);
  endtask : xfer
endmodule : adrlm_mcu_model
`default_nettype wire

// ---- test/adrlm_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module adrlm_chk #(
  parameter int unsigned WAKE_FILTER_CYC = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic lin_bus_i,
  input wire logic txd_drive_i,
  input wire logic rxd_o,
  input wire logic lin_o,
  input wire logic lin_oe_o,
  input wire logic tx_enable_o,
  input wire logic cs_on_o,
  input wire logic [3:0] converter_source_o,
  input wire logic converter_source_valid_o,
  input wire logic sys_wake_o,
  input wire logic wake_reset_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // bus pins
  property p_lin_low; lin_o == 1'b0; endproperty
  a_lin_low: assert property (p_lin_low) else $error("lin data not low");
  property p_oe_en; lin_oe_o |-> $past(tx_enable_o); endproperty
  a_oe_en: assert property (p_oe_en) else $error("driver on while disabled");
  property p_tx_mode; mode_i != 2'h0 |-> !tx_enable_o; endproperty
  a_tx_mode: assert property (p_tx_mode) else $error("transmitter on in low power");
  property p_rxd_hi; lin_bus_i [*4] |=> rxd_o; endproperty
  a_rxd_hi: assert property (p_rxd_hi) else $error("rxd low on recessive bus");
  property p_rxd_lo; !lin_bus_i [*4] |=> !rxd_o; endproperty
  a_rxd_lo: assert property (p_rxd_lo) else $error("rxd high on dominant bus");
  property p_txd_pull; !txd_drive_i [*4] |=> !lin_oe_o; endproperty
  a_txd_pull: assert property (p_txd_pull) else $error("floating txd drives bus");
  // ==========================================================
  // analog mux and wake
  property p_cs_run; cs_on_o |-> $past(mode_i) == 2'h0; endproperty
  a_cs_run: assert property (p_cs_run) else $error("current source on in low power");
  property p_src_ok; converter_source_valid_o == (converter_source_o <= 4'hB && converter_source_o != 4'h7); endproperty
  a_src_ok: assert property (p_src_ok) else $error("source valid wrong");
  property p_swake; sys_wake_o |-> mode_i == 2'h1 ##1 !sys_wake_o; endproperty
  a_swake: assert property (p_swake) else $error("stop wake outside stop");
  property p_wreset; wake_reset_o |-> mode_i == 2'h3 ##1 !wake_reset_o; endproperty
  a_wreset: assert property (p_wreset) else $error("sleep wake outside sleep");
endmodule : adrlm_chk
bind adrlm_top adrlm_chk #(.WAKE_FILTER_CYC(WAKE_FILTER_CYC)) i_chk (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .mode_i(mode_i),
  .lin_bus_i(lin_bus_i),
  .txd_drive_i(txd_drive_i),
  .rxd_o(rxd_o),
  .lin_o(lin_o),
  .lin_oe_o(lin_oe_o),
  .tx_enable_o(tx_enable_o),
  .cs_on_o(cs_on_o),
  .converter_source_o(converter_source_o),
  .converter_source_valid_o(converter_source_valid_o),
  .sys_wake_o(sys_wake_o),
  .wake_reset_o(wake_reset_o)
);
`default_nettype wire

// ---- test/test_analog_die_reset_lin_mux_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_analog_die_reset_lin_mux_control;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] mode_i = 2'h0;
  logic [4:0] warm = 5'h00;
  logic dom = 1'b0, txd = 1'b1, txd_dr = 1'b0, clim = 1'b0, wkin = 1'b0;
  logic sck, mosi, ss_n, miso, rd_vld, rxd, lin, oe, tx_en, cs_on, src_vld, gain, swake, wreset;
  logic [7:0] rdat, e_m;
  logic [1:0] slew, lvl;
  logic [3:0] src;
  wire bus = !oe && !dom;
  int errors = 0, checks = 0;
  logic [7:0] exp_q[$];
  logic [31:0] rnd = 32'hBA92;
  adrlm_top #(.WAKE_FILTER_CYC(20)) i_dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(1'b1),
    .mode_i(mode_i),
    .pin_reset_i(~warm[0]),
    .wdog_timeout_i(warm[1]),
    .wdog_bad_service_i(warm[2]),
    .overtemp_i(warm[3]),
    .undervolt_i(warm[4]),
    .lin_bus_i(bus),
    .txd_i(txd),
    .txd_drive_i(txd_dr),
    .lin_cur_limit_i(clim),
    .wake_input_i(wkin),
    .spi_sck_i(sck),
    .spi_mosi_i(mosi),
    .spi_ss_n_i(ss_n),
    .spi_miso_o(miso),
    .rxd_o(rxd),
    .lin_o(lin),
    .lin_oe_o(oe),
    .slew_select_o(slew),
    .tx_enable_o(tx_en),
    .cs_on_o(cs_on),
    .current_level_select_o(lvl),
    .converter_source_o(src),
    .converter_source_valid_o(src_vld),
    .sense_gain_select_o(gain),
    .sys_wake_o(swake),
    .wake_reset_o(wreset)
  );
  adrlm_mcu_model i_mcu (.sys_clk_i(sys_clk_i), .miso_i(miso), .sck_o(sck), .mosi_o(mosi), .ss_n_o(ss_n),
    .rd_vld_o(rd_vld), .rd_o(rdat));
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task cyc(input int n); repeat (n) @(negedge sys_clk_i); endtask : cyc
  task wr(input logic [6:0] a, input logic [7:0] d); i_mcu.xfer(1'b1, a, d); endtask : wr
  task rd(input logic [6:0] a, input logic [7:0] e); exp_q.push_back(e); i_mcu.xfer(1'b0, a, 8'h00); endtask : rd
  task wake(input logic [1:0] m, input logic k, input int lo);
    logic hit;
    hit = 1'b0;
    mode_i = m;
    cyc(5);
    if (k) wkin = ~wkin;
    else begin
      dom = 1'b1;
      cyc(lo);
      dom = 1'b0;
    end
    repeat (20) begin @(negedge sys_clk_i); hit = hit | swake | wreset; end
    mode_i = 2'h0;
    `CHK("wake", (lo > 20 || k), hit)
  endtask : wake
  task summarize();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  always @(posedge sys_clk_i) if (rd_vld === 1'b1) begin
    e_m = exp_q.pop_front();
    `CHK("read", e_m, rdat)
  end
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  // watchdog sized at several times the expected run of about 70 us
  initial begin #400000; errors++; summarize(); end
  // ==========================================================
  // scenarios
  initial begin
    cyc(5);
    rst_i = 1'b0;
    cyc(4);
    `CHK("rxd", 1'b1, rxd)
    `CHK("slew", 2'h0, slew)
    rd(7'h0D, 8'h01);
    rd(7'h08, 8'h00);
    wr(7'h0D, 8'h00);
    rd(7'h0D, 8'h01);
    wr(7'h0D, 8'h01);
    rd(7'h0D, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(7'h08, 8'h55);
      warm[i] = 1'b1;
      cyc(10);
      warm[i] = 1'b0;
      cyc(10);
      rd(7'h08, 8'h00);
      rd(7'h0D, 8'h01 << ((i == 0) ? 1 : (i < 3) ? 2 : i));
      wr(7'h0D, 8'hFF);
      rd(7'h0D, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      wr(7'h08, rnd[7:0]);
      rd(7'h08, rnd[7:0]);
      `CHK("src", rnd[3:0], src)
      `CHK("gain", rnd[4], gain)
      `CHK("lvl", rnd[6:5], lvl)
      `CHK("cs_on", 1'b0, cs_on)
    end
    wr(7'h0C, 8'h05);
    `CHK("slew", 2'h2, slew)
    `CHK("tx_en", 1'b1, tx_en)
    txd_dr = 1'b1;
    txd = 1'b0;
    cyc(6);
    `CHK("oe", 1'b1, oe)
    `CHK("rxd", 1'b0, rxd)
    txd = 1'b1;
    cyc(6);
    `CHK("oe", 1'b0, oe)
    txd = 1'b0;
    txd_dr = 1'b0;
    cyc(6);
    `CHK("oe", 1'b0, oe)
    wr(7'h08, 8'h8A);
    `CHK("cs_on", 1'b1, cs_on)
    mode_i = 2'h1;
    cyc(4);
    `CHK("cs_on", 1'b0, cs_on)
    `CHK("tx_en", 1'b0, tx_en)
    mode_i = 2'h0;
    wr(7'h08, 8'h89);
    `CHK("cs_on", 1'b0, cs_on)
    clim = 1'b1;
    cyc(10);
    `CHK("tx_en", 1'b1, tx_en)
    cyc(2000);
    `CHK("tx_en", 1'b0, tx_en)
    clim = 1'b0;
    rd(7'h0E, 8'h01);
    wr(7'h0E, 8'h01);
    `CHK("tx_en", 1'b1, tx_en)
    wr(7'h09, 8'h04);
    wake(2'h1, 1'b0, 10);
    wake(2'h1, 1'b0, 30);
    rd(7'h0A, 8'h04);
    wr(7'h0A, 8'h04);
    wake(2'h3, 1'b0, 30);
    rd(7'h0D, 8'h20);
    wr(7'h0D, 8'h20);
    wake(2'h3, 1'b1, 0);
    rd(7'h0D, 8'h40);
    cyc(10);
    summarize();
  end
endmodule : test_analog_die_reset_lin_mux_control
`default_nettype wire
